// ===== design/rtcw_pkg.sv
// Package for the real-time counter and periodic wakeup register bank.
// Assumes a 32-bit register port with byte addresses; all users import it.
package rtcw_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CLK_SRC    = 8'h00;
  localparam logic [7:0] OFS_RTC_CTL    = 8'h10;
  localparam logic [7:0] OFS_RTC_CNT    = 8'h14;
  localparam logic [7:0] OFS_PIN_SEL    = 8'h40;
  localparam logic [7:0] OFS_WAKE_EN    = 8'h44;
  localparam logic [7:0] OFS_CORE1_VEC  = 8'h50;
  localparam logic [7:0] OFS_CORE0_VEC  = 8'h54;
  localparam logic [7:0] OFS_REC_PTR    = 8'h58;
  localparam logic [7:0] OFS_PWR_CTL    = 8'h60;
  localparam logic [7:0] OFS_SOC_CTL    = 8'h70;

  // ---------------------------------------------------------------
  // Clock source register fields
  // ---------------------------------------------------------------
  localparam int CS_SLOW_RC_EN   = 19;
  localparam int CS_MAIN_XTAL_EN = 18;
  localparam int CS_SLOW_XTAL_EN = 16;
  localparam int CS_SLOW_TRIM_LO = 8;
  localparam int CS_FAST_TRIM_LO = 0;
  localparam logic [7:0] SLOW_TRIM_RST  = 8'hdf;
  localparam logic [7:0] FAST_TRIM_RST  = 8'h8f;
  localparam logic [7:0] SLOW_TRIM_FIX  = 8'hc0;
  localparam logic       MAIN_XTAL_RST  = 1'b1;

  // ---------------------------------------------------------------
  // Counter status and control register fields
  // ---------------------------------------------------------------
  localparam int RC_RUN_EN    = 31;
  localparam int RC_MATCH_IE  = 30;
  localparam int RC_MATCH_F   = 29;
  localparam int RC_WRAP_F    = 28;
  localparam int RC_MATCH_LO  = 16;
  localparam int RC_PER_EN    = 15;
  localparam int RC_PER_IE    = 14;
  localparam int RC_PER_F     = 13;
  localparam int RC_WRAP_EN   = 12;
  localparam int RC_SEL_LO    = 10;
  localparam int RC_PER_LO    = 0;

  // Counter bit range compared against the match compare field
  localparam int CNT_MATCH_LO = 10;
  localparam int CNT_MATCH_HI = 21;

  // ---------------------------------------------------------------
  // Clock selection and prescaling
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RTCW_SEL_SLOW_RC   = 2'b00,
    RTCW_SEL_SLOW_XTAL = 2'b01,
    RTCW_SEL_FAST_DIV  = 2'b10,
    RTCW_SEL_FAST      = 2'b11
  } rtcw_sel_type;

  localparam logic [8:0] PRE_FAST_MAX = 9'h1ff;
  localparam logic [4:0] PRE_MAIN_MAX = 5'h1f;

  // ---------------------------------------------------------------
  // Masks and reset values of the mapped storage registers
  // ---------------------------------------------------------------
  localparam logic [31:0] PIN_SEL_MASK   = 32'h77777777;
  localparam logic [31:0] CORE1_VEC_RST  = 32'hfffffffd;
  localparam logic [31:0] CORE0_VEC_RST  = 32'h0ffffffe;
  localparam logic [31:0] REC_PTR_RST    = 32'hfffffffc;
  localparam logic [31:0] ZERO_RST       = 32'h00000000;

endpackage

// ===== design/rtcw_top.sv
// Register bank and real-time counter with match, wrap and periodic events.
// Assumes the source clocks arrive as asynchronous pins slower than half
// of i_clk, and that the power-on/low-voltage reset is a separate input.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps

// Functional notes
// [R1] Run enable gates and clears counter logic
// [R2] Match interrupt needs flag and enable
// [R3] Match flag when counter bits 21..10 equal
// [R4] Flags clear on write one only
// [R5] Wrap flag on all ones to zero
// [R6] Wrap requests need wrap enable, irq enable; wrap wake needs wrap enable only
// [R7] Match value changed only while stopped
// [R8] Periodic interrupt needs enable, flag, irq enable
// [R9] Periodic flag on low-bits offset match
// [R10] Periodic compare is value plus one
// [R11] Periodic value changed only while disabled
// [R12] Two-bit select picks one of four sources
// [R13] Clock select changed only while stopped
// [R14] Software enables slow source before selecting
// [R15] Counter register reads live value
// [R16] Eight three-bit pin selectors, nibble top reserved
// [R17] Sleep keeps crystal driven, clock gated
// [R18] Oscillator enables reset only by power reset
// [R19] Trims binary weighted, slow trim never all-ones
// [R20] Slow trim upper bits forced to one
// [R21] Fast trim bandgap bits kept by software
// [R22] Software clears flags before low power
// [R23] Fixed divide by 32, plus 512 option
// [R24] Reserved bits read zero, ignore writes
module rtcw_top
  import rtcw_pkg::*;
(
  // Clock, resets and enable
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_pwr_rst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Counter source clocks, asynchronous pins
  input  wire logic        i_slow_rc_clk,
  input  wire logic        i_slow_xtal_clk,
  input  wire logic        i_fast_rc_clk,
  // Power mode from the sequencer, same clock
  input  wire logic        i_low_power,
  // Requests
  output logic             o_match_irq,
  output logic             o_wrap_irq,
  output logic             o_periodic_irq,
  output logic             o_match_wake,
  output logic             o_wrap_wake,
  output logic             o_periodic_wake,
  // Oscillator controls
  output logic             o_slow_rc_enable,
  output logic             o_slow_crystal_enable,
  output logic             o_main_crystal_enable,
  output logic             o_main_crystal_clk_en,
  output logic      [5:0]  o_slow_rc_trim,
  output logic      [7:0]  o_fast_rc_trim,
  // Wake pin selectors
  output logic      [23:0] o_wake_pin_choice
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    // Software-visible fields
    logic [7:0]  slow_trim;
    logic [7:0]  fast_trim;
    logic        run_en;
    logic        match_ie;
    logic        match_f;
    logic        wrap_f;
    logic [11:0] match_val;
    logic        per_en;
    logic        per_ie;
    logic        per_f;
    logic        wrap_en;
    logic [1:0]  clk_sel;
    logic [9:0]  per_val;

    // Counter, prescalers, periodic divider
    logic [31:0] cnt;
    logic [8:0]  pre_fast;
    logic [4:0]  pre_main;
    logic [9:0]  per_cnt;

    // One sampler bit per source clock
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [2:0]  sync_c;

    // Plain storage of mapped neighbours
    logic [31:0] pin_sel;
    logic [31:0] wake_en;
    logic [31:0] core1_vec;
    logic [31:0] core0_vec;
    logic [31:0] rec_ptr;
    logic [31:0] pwr_ctl;
    logic [31:0] soc_ctl;

    // Registered outputs
    logic [31:0] rdata;
    logic        match_irq;
    logic        wrap_irq;
    logic        per_irq;
    logic        match_wake;
    logic        wrap_wake;
    logic        per_wake;
    logic        xtal_clk_en;
  } rtcw_state_type;

  // Oscillator enables live on the power reset only
  typedef struct packed {
    logic slow_rc_en;
    logic main_xtal_en;
    logic slow_xtal_en;
  } rtcw_osc_type;

  rtcw_state_type st_r;
  rtcw_state_type st_nxt;
  rtcw_osc_type   osc_r;
  rtcw_osc_type   osc_nxt;

  localparam rtcw_state_type ST_RST = '{
    slow_trim: SLOW_TRIM_RST,
    fast_trim: FAST_TRIM_RST,
    core1_vec: CORE1_VEC_RST,
    core0_vec: CORE0_VEC_RST,
    rec_ptr:   REC_PTR_RST,
    default:   '0
  };

  localparam rtcw_osc_type OSC_RST = '{
    main_xtal_en: MAIN_XTAL_RST,
    default:      1'b0
  };

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0]  edges;
    logic        src_edge;
    logic        tick32;
    logic        tick;
    logic        wr_ctl;
    logic [31:0] w;
    logic        set_match;
    logic        set_wrap;
    logic        set_per;
    edges     = '0;
    src_edge  = 1'b0;
    tick32    = 1'b0;
    tick      = 1'b0;
    wr_ctl    = 1'b0;
    w         = i_wdata;
    set_match = 1'b0;
    set_wrap  = 1'b0;
    set_per   = 1'b0;
    st_nxt    = st_r;
    osc_nxt   = osc_r;

    // Three-stage samplers; only stages two and three feed the edges
    // A source must stay high and low one cycle or edges are lost
    st_nxt.sync_a = {i_fast_rc_clk, i_slow_xtal_clk, i_slow_rc_clk};
    st_nxt.sync_b = st_r.sync_a;
    st_nxt.sync_c = st_r.sync_b;
    edges = st_r.sync_b & ~st_r.sync_c;

    // Source choice and prescaling
    unique case (rtcw_sel_type'(st_r.clk_sel))
      RTCW_SEL_SLOW_RC:   src_edge = edges[0];           // [R12]
      RTCW_SEL_SLOW_XTAL: src_edge = edges[1];           // [R12]
      RTCW_SEL_FAST_DIV: begin
        src_edge = edges[2] && (st_r.pre_fast == PRE_FAST_MAX); // [R23]
      end
      RTCW_SEL_FAST:      src_edge = edges[2];           // [R12]
    endcase

    // The 512 stage idles unless selected, saving power
    if (edges[2] && st_r.clk_sel == RTCW_SEL_FAST_DIV) begin
      st_nxt.pre_fast = st_r.pre_fast + 9'h001;          // [R23]
    end
    if (src_edge) begin
      st_nxt.pre_main = st_r.pre_main + 5'h01;           // [R23]
      tick32 = (st_r.pre_main == PRE_MAIN_MAX);
    end
    tick = tick32 && st_r.run_en;                        // [R1]

    // Counter and events
    if (tick) begin
      st_nxt.cnt = st_r.cnt + 32'h00000001;
      set_wrap = (st_r.cnt == 32'hffffffff);             // [R5]
      // Compare the incremented value: flag marks arrival
      set_match = (st_nxt.cnt[CNT_MATCH_HI:CNT_MATCH_LO]
                   == st_r.match_val);                   // [R3]
      if (st_r.per_en) begin
        // Counts 0..value, so the period is value plus one ticks
        if (st_r.per_cnt == st_r.per_val) begin          // [R10]
          st_nxt.per_cnt = 10'h000;
          set_per = 1'b1;                                // [R9]
        end else begin
          st_nxt.per_cnt = st_r.per_cnt + 10'h001;
        end
      end
    end
    // Divider restarts whenever the periodic function is off
    if (!st_r.per_en) begin
      st_nxt.per_cnt = 10'h000;
    end

    // Register writes
    // Unmapped offsets fall to the default and change nothing
    if (i_wr) begin
      unique case (i_addr)
        OFS_CLK_SRC: begin
          osc_nxt.slow_rc_en   = w[CS_SLOW_RC_EN];
          osc_nxt.main_xtal_en = w[CS_MAIN_XTAL_EN];
          osc_nxt.slow_xtal_en = w[CS_SLOW_XTAL_EN];
          st_nxt.slow_trim = w[CS_SLOW_TRIM_LO +: 8]
                             | SLOW_TRIM_FIX;            // [R20]
          st_nxt.fast_trim = w[CS_FAST_TRIM_LO +: 8];    // [R19]
        end
        OFS_RTC_CTL: begin
          wr_ctl = 1'b1;
          st_nxt.run_en    = w[RC_RUN_EN];
          st_nxt.match_ie  = w[RC_MATCH_IE];
          st_nxt.match_val = w[RC_MATCH_LO +: 12];
          st_nxt.per_en    = w[RC_PER_EN];
          st_nxt.per_ie    = w[RC_PER_IE];
          st_nxt.wrap_en   = w[RC_WRAP_EN];
          st_nxt.clk_sel   = w[RC_SEL_LO +: 2];
          st_nxt.per_val   = w[RC_PER_LO +: 10];
        end
        OFS_PIN_SEL:   st_nxt.pin_sel = w & PIN_SEL_MASK; // [R16]
        OFS_WAKE_EN:   st_nxt.wake_en = w;
        OFS_CORE1_VEC: st_nxt.core1_vec = w;
        OFS_CORE0_VEC: st_nxt.core0_vec = w;
        OFS_REC_PTR:   st_nxt.rec_ptr = w;
        OFS_PWR_CTL:   st_nxt.pwr_ctl = w;
        OFS_SOC_CTL:   st_nxt.soc_ctl = w;
        default: ;                                       // [R24]
      endcase
    end

    // Flags: a set in the clearing cycle wins
    if (wr_ctl && w[RC_MATCH_F]) begin
      st_nxt.match_f = 1'b0;                             // [R4]
    end
    if (wr_ctl && w[RC_WRAP_F]) begin
      st_nxt.wrap_f = 1'b0;                              // [R4]
    end
    if (wr_ctl && w[RC_PER_F]) begin
      st_nxt.per_f = 1'b0;                               // [R4]
    end
    if (set_match) begin
      st_nxt.match_f = 1'b1;                             // [R3]
    end
    if (set_wrap) begin
      st_nxt.wrap_f = 1'b1;                              // [R5]
    end
    if (set_per) begin
      st_nxt.per_f = 1'b1;                               // [R9]
    end

    // Counter logic held cleared while stopped; release is clocked
    // Clearing on any enable change drops stale prescaler phase
    if (!st_nxt.run_en || (st_r.run_en != st_nxt.run_en)) begin
      st_nxt.cnt      = 32'h00000000;                    // [R1]
      st_nxt.pre_fast = 9'h000;                          // [R1]
      st_nxt.pre_main = 5'h00;                           // [R1]
      st_nxt.per_cnt  = 10'h000;                         // [R1]
    end

    // Requests
    // Built from next state so they move with their flags
    st_nxt.match_irq  = st_nxt.match_f && st_nxt.match_ie;       // [R2]
    st_nxt.match_wake = st_nxt.match_f;
    st_nxt.wrap_wake  = st_nxt.wrap_f && st_nxt.wrap_en;         // [R6]
    // Wrap irq shares the match irq enable
    st_nxt.wrap_irq   = st_nxt.wrap_wake && st_nxt.match_ie;     // [R6]
    st_nxt.per_wake   = st_nxt.per_en && st_nxt.per_f;           // [R9]
    st_nxt.per_irq    = st_nxt.per_wake && st_nxt.per_ie;        // [R8]
    // Crystal keeps running in low power, its clock does not reach us
    st_nxt.xtal_clk_en = osc_nxt.main_xtal_en && !i_low_power;   // [R17]

    // Read data, valid the cycle after the strobe only
    // A counter read shows the value before this edge's tick
    st_nxt.rdata = 32'h00000000;
    if (i_rd) begin
      unique case (i_addr)
        OFS_CLK_SRC: begin
          st_nxt.rdata[CS_SLOW_RC_EN]   = osc_r.slow_rc_en;
          st_nxt.rdata[CS_MAIN_XTAL_EN] = osc_r.main_xtal_en;
          st_nxt.rdata[CS_SLOW_XTAL_EN] = osc_r.slow_xtal_en;
          st_nxt.rdata[CS_SLOW_TRIM_LO +: 8] = st_r.slow_trim;
          st_nxt.rdata[CS_FAST_TRIM_LO +: 8] = st_r.fast_trim;
        end
        OFS_RTC_CTL: begin
          st_nxt.rdata[RC_RUN_EN]          = st_r.run_en;
          st_nxt.rdata[RC_MATCH_IE]        = st_r.match_ie;
          st_nxt.rdata[RC_MATCH_F]         = st_r.match_f;
          st_nxt.rdata[RC_WRAP_F]          = st_r.wrap_f;
          st_nxt.rdata[RC_MATCH_LO +: 12]  = st_r.match_val;
          st_nxt.rdata[RC_PER_EN]          = st_r.per_en;
          st_nxt.rdata[RC_PER_IE]          = st_r.per_ie;
          st_nxt.rdata[RC_PER_F]           = st_r.per_f;
          st_nxt.rdata[RC_WRAP_EN]         = st_r.wrap_en;
          st_nxt.rdata[RC_SEL_LO +: 2]     = st_r.clk_sel;
          st_nxt.rdata[RC_PER_LO +: 10]    = st_r.per_val;
        end
        OFS_RTC_CNT:   st_nxt.rdata = st_r.cnt;          // [R15]
        OFS_PIN_SEL:   st_nxt.rdata = st_r.pin_sel;      // [R16]
        OFS_WAKE_EN:   st_nxt.rdata = st_r.wake_en;
        OFS_CORE1_VEC: st_nxt.rdata = st_r.core1_vec;
        OFS_CORE0_VEC: st_nxt.rdata = st_r.core0_vec;
        OFS_REC_PTR:   st_nxt.rdata = st_r.rec_ptr;
        OFS_PWR_CTL:   st_nxt.rdata = st_r.pwr_ctl;
        OFS_SOC_CTL:   st_nxt.rdata = st_r.soc_ctl;
        default:       st_nxt.rdata = 32'h00000000;      // [R24]
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_RST;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Ordinary resets leave the oscillators alone
  // so a warm reset cannot stop a running crystal
  always_ff @(posedge i_clk or posedge i_pwr_rst) begin
    if (i_pwr_rst) begin
      osc_r <= OSC_RST;                                  // [R18]
    end else if (i_ce) begin
      osc_r <= osc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_rdata               = st_r.rdata;
  assign o_match_irq           = st_r.match_irq;
  assign o_wrap_irq            = st_r.wrap_irq;
  assign o_periodic_irq        = st_r.per_irq;
  assign o_match_wake          = st_r.match_wake;
  assign o_wrap_wake           = st_r.wrap_wake;
  assign o_periodic_wake       = st_r.per_wake;
  assign o_slow_rc_enable      = osc_r.slow_rc_en;
  assign o_slow_crystal_enable = osc_r.slow_xtal_en;
  assign o_main_crystal_enable = osc_r.main_xtal_en;
  assign o_main_crystal_clk_en = st_r.xtal_clk_en;
  assign o_slow_rc_trim        = st_r.slow_trim[5:0];    // [R20]
  assign o_fast_rc_trim        = st_r.fast_trim;
  // Selector n at bits 3n+2..3n; reserved nibble bits dropped
  assign o_wake_pin_choice     = {st_r.pin_sel[30:28], st_r.pin_sel[26:24],
                                  st_r.pin_sel[22:20], st_r.pin_sel[18:16],
                                  st_r.pin_sel[14:12], st_r.pin_sel[10:8],
                                  st_r.pin_sel[6:4],   st_r.pin_sel[2:0]};

endmodule

// ===== verif/rtcw_asserts.sv
// Port checker for the counter register bank, bound into rtcw_top.
// Assumes one clock domain; internal flags are judged via request outputs.
`timescale 1ns/10ps
module rtcw_asserts
  import rtcw_pkg::*;
(
  // Clock, resets and bus
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_pwr_rst,
  input wire logic        i_ce,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_low_power,
  input wire logic [31:0] o_rdata,
  // Requests and oscillator controls
  input wire logic        o_match_irq,
  input wire logic        o_wrap_irq,
  input wire logic        o_periodic_irq,
  input wire logic        o_wrap_wake,
  input wire logic        o_periodic_wake,
  input wire logic        o_slow_rc_enable,
  input wire logic        o_slow_crystal_enable,
  input wire logic        o_main_crystal_enable,
  input wire logic        o_main_crystal_clk_en,
  input wire logic [5:0]  o_slow_rc_trim,
  input wire logic [7:0]  o_fast_rc_trim,
  input wire logic [23:0] o_wake_pin_choice
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  wire logic wr_cs = i_wr && i_ce && i_addr == OFS_CLK_SRC;
  wire logic wr_rc = i_wr && i_ce && i_addr == OFS_RTC_CTL;
  wire logic wr_ps = i_wr && i_ce && i_addr == OFS_PIN_SEL;

  function automatic logic is_map(logic [7:0] a);
    return a inside {OFS_CLK_SRC, OFS_RTC_CTL, OFS_RTC_CNT, OFS_PIN_SEL,
      OFS_WAKE_EN, OFS_CORE1_VEC, OFS_CORE0_VEC, OFS_REC_PTR, OFS_PWR_CTL,
      OFS_SOC_CTL};
  endfunction

  function automatic logic [23:0] pack(logic [31:0] d);
    logic [23:0] p;
    for (int n = 0; n < 8; n++) begin
      p[3*n +: 3] = d[4*n +: 3];
    end
    return p;
  endfunction

  // Stop write, an idle cycle, then a counter read
  sequence stop_wr;
    wr_rc && !i_wdata[RC_RUN_EN];
  endsequence
  sequence cnt_rd;
    i_rd && i_ce && i_addr == OFS_RTC_CNT;
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  hole_read_a:
    assert property (i_rd && i_ce && !is_map(i_addr) |=> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  trim_write_a:
    assert property (wr_cs |=> o_fast_rc_trim == $past(i_wdata[7:0])
      && o_slow_rc_trim == $past(i_wdata[13:8]))
    else $error("trim outputs differ from written value");
  pin_write_a:
    assert property (wr_ps |=> o_wake_pin_choice == pack($past(i_wdata)))
    else $error("pin choice differs from written fields");
  stop_clear_a:
    assert property (stop_wr ##1 !i_wr ##1 cnt_rd |=> o_rdata == 32'h0)
    else $error("counter not cleared after stop");
  xtal_gate_a:
    assert property (i_low_power [*2] |-> !o_main_crystal_clk_en)
    else $error("crystal clock not gated in low power");
  por_enables_a:
    assert property ($fell(i_pwr_rst) |-> o_main_crystal_enable
      && !o_slow_rc_enable && !o_slow_crystal_enable)
    else $error("oscillator enables wrong after power reset");
  match_mask_a:
    assert property (wr_rc && !i_wdata[RC_MATCH_IE] |=> !o_match_irq)
    else $error("match request without its enable");
  wrap_mask_a:
    assert property (wr_rc && !i_wdata[RC_WRAP_EN] |=>
      !o_wrap_irq && !o_wrap_wake)
    else $error("wrap request without its enable");
  per_mask_a:
    assert property (wr_rc && !i_wdata[RC_PER_EN] |=>
      !o_periodic_irq && !o_periodic_wake)
    else $error("periodic request while disabled");
endmodule

bind rtcw_top rtcw_asserts u_chk (
  .i_clk, .i_rst, .i_pwr_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_low_power, .o_rdata, .o_match_irq, .o_wrap_irq, .o_periodic_irq,
  .o_wrap_wake, .o_periodic_wake, .o_slow_rc_enable, .o_slow_crystal_enable,
  .o_main_crystal_enable, .o_main_crystal_clk_en, .o_slow_rc_trim,
  .o_fast_rc_trim, .o_wake_pin_choice
);

// ===== verif/rtcw_top_bench.sv
// Self-checking bench for the counter register bank.
// Drives all ports; source clocks come from one gated 24 ns toggle.
`timescale 1ns/10ps
module rtcw_top_bench;
  import rtcw_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_pwr_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_low_power = 1'b0;
  logic        src = 1'b0;
  logic [2:0]  src_on = 3'h0;
  logic [31:0] o_rdata, rv, c1;
  logic        o_match_irq, o_wrap_irq, o_periodic_irq;
  logic        o_match_wake, o_wrap_wake, o_periodic_wake;
  logic        o_slow_rc_enable, o_slow_crystal_enable;
  logic        o_main_crystal_enable, o_main_crystal_clk_en;
  logic [5:0]  o_slow_rc_trim;
  logic [7:0]  o_fast_rc_trim;
  logic [23:0] o_wake_pin_choice;
  int          err_count = 0;
  int          checks = 0;
  // Offset and reset value; first six are plain storage
  localparam logic [39:0] RT [13] = '{40'h4400000000, 40'h50fffffffd,
    40'h540ffffffe, 40'h58fffffffc, 40'h6000000000, 40'h7000000000,
    40'h000004df8f, 40'h1000000000, 40'h1400000000, 40'h4000000000,
    40'h0400000000, 40'h3c00000000, 40'h1200000000};

  // Rising edges land at 2 mod 4 ns, source edges at 0 mod 4: no ties
  always #2 i_clk = ~i_clk;
  always #12 src = ~src;

  rtcw_top dut (
    .i_clk, .i_rst, .i_pwr_rst, .i_ce, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_slow_rc_clk(src & src_on[0]),
    .i_slow_xtal_clk(src & src_on[1]), .i_fast_rc_clk(src & src_on[2]),
    .i_low_power, .o_match_irq, .o_wrap_irq, .o_periodic_irq,
    .o_match_wake, .o_wrap_wake, .o_periodic_wake, .o_slow_rc_enable,
    .o_slow_crystal_enable, .o_main_crystal_enable, .o_main_crystal_clk_en,
    .o_slow_rc_trim, .o_fast_rc_trim, .o_wake_pin_choice
  );

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(logic por);
    @(posedge i_clk);
    if (por) i_pwr_rst <= 1'b1;
    else i_rst <= 1'b1;
    @(posedge i_clk);
    i_pwr_rst <= 1'b0;
    i_rst <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 13; i++) begin
      rd(RT[i][39:32]);
      chk("reset read", RT[i][31:0], rv);
    end
    chk("main xtal en", 1'b1, o_main_crystal_enable);
    chk("slow trim", 6'h1f, o_slow_rc_trim);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 6; i++) begin
      wr(RT[i][39:32], 32'ha5c30f96 ^ 32'(i));
      rd(RT[i][39:32]);
      chk("rw read", 32'ha5c30f96 ^ 32'(i), rv);
    end
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(OFS_WAKE_EN, 32'h0);
    i_ce <= 1'b1;
    rd(OFS_WAKE_EN);
    chk("frozen write", 32'ha5c30f96, rv);
    wr(8'h04, 32'hffffffff);
    rd(8'h04);
    chk("unmapped", 32'h0, rv);
    wr(OFS_PIN_SEL, 32'hfedcba98);
    rd(OFS_PIN_SEL);
    chk("pin sel", 32'h76543210, rv);
    chk("pin choice", 24'hfac688, o_wake_pin_choice);
    wr(OFS_CLK_SRC, 32'hffff155a);
    rd(OFS_CLK_SRC);
    chk("clk src", 32'h000dd55a, rv);
    chk("slow trim", 6'h15, o_slow_rc_trim);
    chk("fast trim", 8'h5a, o_fast_rc_trim);
    chk("rc32 en", 1'b1, o_slow_rc_enable);
    chk("xtal32 en", 1'b1, o_slow_crystal_enable);
    pulse(1'b0);
    rd(OFS_CLK_SRC);
    chk("clk src rst", 32'h000ddf8f, rv);
    pulse(1'b1);
    rd(OFS_CLK_SRC);
    chk("clk src por", 32'h0004df8f, rv);
    @(posedge i_clk);
    i_low_power <= 1'b1;
    wt(3);
    chk("xtal clk gated", 1'b0, o_main_crystal_clk_en);
    chk("xtal driven", 1'b1, o_main_crystal_enable);
    @(posedge i_clk);
    i_low_power <= 1'b0;
    wt(3);
    chk("xtal clk on", 1'b1, o_main_crystal_clk_en);
  endtask
  task automatic t_match();
    @(posedge i_clk);
    src_on <= 3'b100;
    wr(OFS_RTC_CTL, 32'hc0000c00);
    wt(300);
    chk("match irq", 1'b1, o_match_irq);
    rd(OFS_RTC_CTL);
    chk("match flag", 32'he0000c00, rv);
    wr(OFS_RTC_CTL, 32'h80000c00);
    wt(2);
    chk("irq masked", 1'b0, o_match_irq);
    chk("flag kept", 1'b1, o_match_wake);
    rd(OFS_RTC_CNT);
    c1 = rv;
    wt(400);
    rd(OFS_RTC_CNT);
    chk("live count", 1'b1, rv > c1);
    wr(OFS_RTC_CTL, 32'h20000c00);
    rd(OFS_RTC_CNT);
    chk("stop clear", 32'h0, rv);
    chk("flag cleared", 1'b0, o_match_wake);
    rd(OFS_RTC_CTL);
    chk("ctl after clear", 32'h00000c00, rv);
  endtask
  task automatic t_per();
    wr(OFS_RTC_CTL, 32'h8fffcc03);
    wt(740);
    chk("per early", 1'b0, o_periodic_irq);
    wt(160);
    chk("per irq", 1'b1, o_periodic_irq);
    rd(OFS_RTC_CNT);
    chk("tick count", 32'h4, rv);
    wr(OFS_RTC_CTL, 32'h8fff9c03);
    wt(2);
    chk("per masked", 1'b0, o_periodic_irq);
    chk("per wake", 1'b1, o_periodic_wake);
    chk("wrap idle", 32'h0, {o_wrap_irq, o_wrap_wake});
    wr(OFS_RTC_CTL, 32'h0fff2c03);
    rd(OFS_RTC_CTL);
    chk("per clear", 32'h0fff0c03, rv);
  endtask
  task automatic t_sel();
    wr(OFS_CLK_SRC, 32'h000ddf8f);
    for (int s = 0; s < 5; s++) begin
      @(posedge i_clk);
      src_on <= (s == 4) ? 3'b110 : (s < 2) ? 3'(1 << s) : 3'b100;
      wr(OFS_RTC_CTL, 32'h80000000 | (32'(s % 4) << 10));
      wt(900);
      rd(OFS_RTC_CNT);
      chk("sel count", (s % 2 == 0 && s > 0) ? 32'h0 : 32'h4, rv);
      wr(OFS_RTC_CTL, 32'h0);
    end
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  initial begin
    wt(20000);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    i_pwr_rst <= 1'b0;
    t_reset();
    t_rw();
    t_match();
    t_per();
    t_sel();
    stop_test();
  end
endmodule
